// File: include/adc_ctrl_consts.svh
// constants for the converter control logic: offsets, fields, reset values, timing
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH
// byte offsets of the three control registers and the pin share register on the bus
`define OFS_CTRL_FIRST   4'h0
`define OFS_CTRL_SECOND  4'h4
`define OFS_CTRL_THIRD   4'h8
`define OFS_PIN_SHARE    4'hc
// first control register fields
`define BIT_START        7
`define BIT_BUSY         6
`define BIT_POWER        5
// third control register fields
`define BIT_OPAMP        7
`define BIT_BANDGAP      6
`define BIT_REF_MSB      3
// writable masks; unimplemented bits read as zero
`define MASK_FIRST       8'ha0
`define MASK_SECOND      8'he7
`define MASK_THIRD       8'hcf
// reset values
`define RST_REG          8'h00
// conversion timing in converter clock cycles
`define SAMPLE_CYCLES    5'h04
`define CONVERT_CYCLES   5'h0c
`define TOTAL_CYCLES     5'h10
`endif

// File: include/adc_ctrl_pkg.sv
// types shared by the converter control logic
package adc_ctrl_pkg;
	// converter input source
	typedef enum logic [2:0] {
		SRC_PIN, SRC_SUPPLY, SRC_SUPPLY_HALF, SRC_SUPPLY_QUARTER,
		SRC_OPAMP, SRC_OPAMP_HALF, SRC_OPAMP_QUARTER
	} input_source_t;
	// converter reference source
	typedef enum logic [2:0] {
		REF_SUPPLY, REF_EXT, REF_BANDGAP
	} reference_source_t;
	// analog routing bundle toward the macro
	typedef struct packed {
		input_source_t     source;
		reference_source_t reference;
		logic [2:0]        ref_gain;
		logic              opamp_from_bandgap;
	} analog_route_t;
	// conversion sequencer states
	typedef enum logic [1:0] {
		ST_IDLE, ST_SAMPLE, ST_CONVERT
	} conv_state_t;
endpackage

// File: hdl/adc_clock_divider.sv
// converter clock divider: one-cycle enable at fsys divided by 2^code
`timescale 1ns/1ns
module adc_clock_divider #(
	parameter int WIDTH = 7
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// control
	input  wire logic       clear_i,
	input  wire logic [2:0] code_i,
	// enable pulse
	output logic            tick_o
);
	logic [WIDTH-1:0] count_q;   // free running prescaler
	logic [WIDTH-1:0] mask;      // terminal mask for the ratio

	// ratio 2^code; code 0 ticks on every cycle
	always_comb begin
		mask = WIDTH'((1 << code_i) - 1);
	end

	// restart on clear so a conversion starts on a full period
	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i || (count_q & mask) == mask) begin
			count_q <= '0;
		end else begin
			count_q <= count_q + 1'b1;
		end
	end

	// tick when the masked count reaches its end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_o <= 1'b0;
		end else begin
			tick_o <= !clear_i && ((count_q & mask) == mask);
		end
	end
endmodule

// File: hdl/adc_control.sv
// converter control: registers, routing, divider, start handshake and sequencer
// Behaviour
// - input code picks pin, supply or opamp
// - clock code divides fsys by 1 to 128
// - reference code picks supply, external, bandgap
// - reference msb feeds bandgap to opamp
// - bandgap wins over external reference
// - third register bit 6 drives bandgap buffer
// - start rising resets converter, clears busy
// - start falling begins a conversion
// - busy set at start, cleared at end
// - end of conversion raises request flag
// - converter powered only while enable set
// - analog pin drops functions and pull-up
// - analog pin share overrides port direction
// - unimplemented bits read as zero
// - busy flag is read only bit 6
// - converter enable is first register bit 5
// - sixteen cycles: four sample, twelve convert
`timescale 1ns/1ns
`include "adc_ctrl_consts.svh"
module adc_control
	import adc_ctrl_pkg::*;
#(
	parameter int PINS = 8
) (
	// clock and reset
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	// wishbone slave
	input  wire logic            cyc_i,
	input  wire logic            stb_i,
	input  wire logic            we_i,
	input  wire logic [3:0]      adr_i,
	input  wire logic [3:0]      sel_i,
	input  wire logic [31:0]     dat_i,
	output logic      [31:0]     dat_o,
	output logic                 ack_o,
	// analog macro control
	output analog_route_t        route_o,
	output logic                 conv_power_o,
	output logic                 conv_reset_o,
	output logic                 sample_o,
	output logic                 convert_o,
	output logic                 conv_clock_tick_o,
	output logic                 opamp_enable_o,
	output logic                 bandgap_buffer_enable_o,
	// interrupt request toward the controller
	output logic                 conv_irq_flag_o,
	// pin sharing
	input  wire logic [PINS-1:0] pull_up_req_i,
	input  wire logic [PINS-1:0] port_dir_out_i,
	output logic      [PINS-1:0] pin_analog_o,
	output logic      [PINS-1:0] pull_up_o,
	output logic      [PINS-1:0] digital_out_en_o
);
	logic [7:0]      first_q;    // start and power bits
	logic [7:0]      second_q;   // input and clock selects
	logic [7:0]      third_q;    // opamp, bandgap, reference
	logic [PINS-1:0] share_q;    // pin share analog selects
	logic            busy_q;     // conversion busy flag
	logic            start_prev_q; // start bit one cycle ago
	logic            start_rise;
	logic            start_fall;
	logic            go_pending_q; // falling edge waiting for a tick
	logic            tick;
	logic            done;
	conv_state_t     state_q;
	logic [4:0]      cycle_q;    // converter cycles in this conversion
	logic            access;
	logic [7:0]      rd_byte;

	assign access = cyc_i && stb_i && !ack_o;

	// ack one cycle after the request, drop it the next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= access;
		end
	end

	// register writes; byte lane 0 carries the 8-bit registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			first_q  <= `RST_REG;
			second_q <= `RST_REG;
			third_q  <= `RST_REG;
			share_q  <= '0;
		end else if (access && we_i && sel_i[0]) begin
			case (adr_i)
				`OFS_CTRL_FIRST:  first_q  <= dat_i[7:0] & `MASK_FIRST;
				`OFS_CTRL_SECOND: second_q <= dat_i[7:0] & `MASK_SECOND;
				`OFS_CTRL_THIRD:  third_q  <= dat_i[7:0] & `MASK_THIRD;
				`OFS_PIN_SHARE:   share_q  <= dat_i[PINS-1:0];
				default:          ;
			endcase
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rd_byte = 8'h00;
		case (adr_i)
			`OFS_CTRL_FIRST:  rd_byte = first_q | {1'b0, busy_q, 6'h00};
			`OFS_CTRL_SECOND: rd_byte = second_q;
			`OFS_CTRL_THIRD:  rd_byte = third_q;
			`OFS_PIN_SHARE:   rd_byte = 8'(share_q);
			default:          rd_byte = 8'h00;
		endcase
	end

	// read data is registered with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (access && !we_i) begin
			dat_o <= {24'h00_0000, rd_byte};
		end
	end

	adc_clock_divider #(
		.WIDTH(7)
	) u_div (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.clear_i(start_rise || !first_q[`BIT_POWER]),
		.code_i (second_q[2:0]),
		.tick_o (tick)
	);

	// start bit edges, same clock so no synchroniser is needed
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_prev_q <= 1'b0;
		end else begin
			start_prev_q <= first_q[`BIT_START];
		end
	end
	assign start_rise = first_q[`BIT_START] && !start_prev_q;
	assign start_fall = !first_q[`BIT_START] && start_prev_q;

	// hold the falling edge until the next converter tick
	always_ff @(posedge clk_i) begin
		if (rst_i || start_rise || !first_q[`BIT_POWER]) begin
			go_pending_q <= 1'b0;
		end else if (start_fall) begin
			go_pending_q <= 1'b1;
		end else if (tick) begin
			go_pending_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || start_rise || !first_q[`BIT_POWER]) begin
			state_q <= ST_IDLE;
			cycle_q <= 5'h00;
		end else if (tick) begin
			case (state_q)
				ST_IDLE: begin
					// begin on the held falling edge
					if (go_pending_q) begin
						state_q <= ST_SAMPLE;
						cycle_q <= 5'h00;
					end
				end
				ST_SAMPLE: begin
					cycle_q <= cycle_q + 5'h01;
					if (cycle_q == `SAMPLE_CYCLES - 5'h01) begin
						state_q <= ST_CONVERT;
					end
				end
				ST_CONVERT: begin
					cycle_q <= cycle_q + 5'h01;
					if (cycle_q == `TOTAL_CYCLES - 5'h01) begin
						state_q <= ST_IDLE;
						cycle_q <= 5'h00;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
	assign done = tick && state_q == ST_CONVERT && cycle_q == `TOTAL_CYCLES - 5'h01;

	// busy from the falling edge to the last cycle
	always_ff @(posedge clk_i) begin
		if (rst_i || start_rise || !first_q[`BIT_POWER]) begin
			busy_q <= 1'b0;
		end else if (start_fall) begin
			busy_q <= 1'b1;
		end else if (done) begin
			busy_q <= 1'b0;
		end
	end

	// request flag pulses at each end of conversion
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_irq_flag_o <= 1'b0;
		end else begin
			conv_irq_flag_o <= done;
		end
	end

	// macro controls straight from flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_power_o            <= 1'b0;
			conv_reset_o            <= 1'b0;
			sample_o                <= 1'b0;
			convert_o               <= 1'b0;
			conv_clock_tick_o       <= 1'b0;
			opamp_enable_o          <= 1'b0;
			bandgap_buffer_enable_o <= 1'b0;
		end else begin
			// enable is first register bit 5
			conv_power_o            <= first_q[`BIT_POWER];
			conv_reset_o            <= first_q[`BIT_START];
			sample_o                <= state_q == ST_SAMPLE;
			convert_o               <= state_q == ST_CONVERT;
			conv_clock_tick_o       <= tick;
			// opamp bit acts as written; firmware enables it
			opamp_enable_o          <= third_q[`BIT_OPAMP];
			bandgap_buffer_enable_o <= third_q[`BIT_BANDGAP];
		end
	end

	// analog routing decode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			route_o <= '0;
		end else begin
			// input source decode, others as pin
			case (second_q[7:5])
				3'h1:    route_o.source <= SRC_SUPPLY;
				3'h2:    route_o.source <= SRC_SUPPLY_HALF;
				3'h3:    route_o.source <= SRC_SUPPLY_QUARTER;
				3'h5:    route_o.source <= SRC_OPAMP;
				3'h6:    route_o.source <= SRC_OPAMP_HALF;
				3'h7:    route_o.source <= SRC_OPAMP_QUARTER;
				default: route_o.source <= SRC_PIN;
			endcase
			// reference decode; 1001 unused, treated as supply
			case (third_q[3:0])
				4'h1, 4'h2, 4'h3, 4'h4: begin
					route_o.reference <= REF_EXT;
					route_o.ref_gain  <= third_q[2:0];
				end
				4'ha, 4'hb, 4'hc: begin
					route_o.reference <= REF_BANDGAP;
					route_o.ref_gain  <= third_q[2:0];
				end
				default: begin
					route_o.reference <= REF_SUPPLY;
					route_o.ref_gain  <= 3'h1;
				end
			endcase
			route_o.opamp_from_bandgap <= third_q[`BIT_REF_MSB];
		end
	end

	// pin sharing: analog pins lose pull-up and drivers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_analog_o     <= '0;
			pull_up_o        <= '0;
			digital_out_en_o <= '0;
		end else begin
			pin_analog_o     <= share_q;
			pull_up_o        <= pull_up_req_i & ~share_q;
			digital_out_en_o <= port_dir_out_i & ~share_q;
		end
	end

	// busy falls on the completing tick
	property p_busy_end;
		@(posedge clk_i) disable iff (rst_i)
		done && !start_rise |=> !busy_q;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy not cleared at end");

	property p_rise_reset;
		@(posedge clk_i) disable iff (rst_i)
		start_rise |=> !busy_q && state_q == ST_IDLE;
	endproperty
	a_rise_reset: assert property (p_rise_reset) else $error("start rise did not reset");

	property p_fall_busy;
		@(posedge clk_i) disable iff (rst_i)
		start_fall && first_q[`BIT_POWER] |=> busy_q;
	endproperty
	a_fall_busy: assert property (p_fall_busy) else $error("busy not set at start");

	// flag follows done by one cycle
	property p_irq;
		@(posedge clk_i) disable iff (rst_i)
		done |=> conv_irq_flag_o;
	endproperty
	a_irq: assert property (p_irq) else $error("request flag missing");

	// sample lasts four ticks before convert
	property p_sample_len;
		@(posedge clk_i) disable iff (rst_i)
		state_q == ST_SAMPLE && tick && cycle_q == 5'h03 && !start_rise && first_q[`BIT_POWER]
			|=> state_q == ST_CONVERT;
	endproperty
	a_sample_len: assert property (p_sample_len) else $error("sampling length wrong");

	// held falling edge starts sampling on the tick
	sequence s_go;
		go_pending_q && tick && state_q == ST_IDLE && !start_rise && first_q[`BIT_POWER];
	endsequence
	sequence s_sampling;
		state_q == ST_SAMPLE && cycle_q == 5'h00;
	endsequence
	property p_go_sample;
		@(posedge clk_i) disable iff (rst_i)
		s_go |=> s_sampling;
	endproperty
	a_go_sample: assert property (p_go_sample) else $error("conversion did not begin");

	property p_reserved;
		@(posedge clk_i) disable iff (rst_i)
		second_q[4:3] == 2'b00 && third_q[5:4] == 2'b00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits set");

	property p_power;
		@(posedge clk_i) disable iff (rst_i)
		!first_q[`BIT_POWER] |=> !busy_q && !conv_power_o;
	endproperty
	a_power: assert property (p_power) else $error("busy while unpowered");

	property p_pull;
		@(posedge clk_i) disable iff (rst_i)
		share_q == $past(share_q) |=> (pull_up_o & $past(share_q)) == '0;
	endproperty
	a_pull: assert property (p_pull) else $error("pull-up on analog pin");
endmodule

// File: verif/sar_adc_control_logic_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
`include "adc_ctrl_consts.svh"
module sar_adc_control_logic_bench
	import adc_ctrl_pkg::*;
	;
	// clock, reset and bus master side
	logic          clk_i = 1'b0;
	logic          rst_i = 1'b1;
	logic          cyc_i = 1'b0;
	logic          stb_i = 1'b0;
	logic          we_i = 1'b0;
	logic [3:0]    adr_i = 4'h0;
	logic [3:0]    sel_i = 4'h0;
	logic [31:0]   dat_i = 32'h0;
	logic [31:0]   dat_o;
	logic          ack_o;
	// analog side and pins
	analog_route_t route_o;
	logic          conv_power_o, conv_reset_o, sample_o, convert_o, conv_clock_tick_o;
	logic          opamp_enable_o, bandgap_buffer_enable_o, conv_irq_flag_o;
	logic [7:0]    pull_up_req_i = 8'h00;
	logic [7:0]    port_dir_out_i = 8'h00;
	logic [7:0]    pin_analog_o, pull_up_o, digital_out_en_o;
	// bookkeeping
	int            mismatches = 0;
	int            compares = 0;
	int            n_samp, n_conv, n_irq;

	adc_control #(.PINS(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .route_o(route_o),
		.conv_power_o(conv_power_o), .conv_reset_o(conv_reset_o), .sample_o(sample_o), .convert_o(convert_o),
		.conv_clock_tick_o(conv_clock_tick_o), .opamp_enable_o(opamp_enable_o),
		.bandgap_buffer_enable_o(bandgap_buffer_enable_o), .conv_irq_flag_o(conv_irq_flag_o),
		.pull_up_req_i(pull_up_req_i), .port_dir_out_i(port_dir_out_i), .pin_analog_o(pin_analog_o),
		.pull_up_o(pull_up_o), .digital_out_en_o(digital_out_en_o));

	// 100 MHz system clock
	always #5 clk_i = ~clk_i;

	// phase lengths counted in system cycles, cleared by the scenario
	always @(posedge clk_i) begin
		if (sample_o === 1'b1) n_samp++;
		if (convert_o === 1'b1) n_conv++;
		if (conv_irq_flag_o === 1'b1) n_irq++;
	end

	// verdict and end of run
	task automatic close_out();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one classic cycle; held until ack is sampled, then released for a cycle
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'h1;
		dat_i <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 16);
		if (ack_o !== 1'b1) begin
			mismatches++;
			close_out();
		end else begin
			q = dat_o;
			cyc_i <= 1'b0;
			stb_i <= 1'b0;
			we_i <= 1'b0;
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
		repeat (2) @(posedge clk_i);
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		logic [31:0] q;
		wb(1'b0, a, 8'h00, q);
		check(q, {24'h0, e});
	endtask

	// cycles up to the next divider tick, bounded
	task automatic gap(output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (conv_clock_tick_o !== 1'b1 && n < 400);
		if (conv_clock_tick_o !== 1'b1) begin
			mismatches++;
			close_out();
		end
	endtask

	// first register reset value, read-only and unimplemented bits, unmapped place
	task automatic t_regs();
		rd_chk(`OFS_CTRL_FIRST, 8'h00);
		wr(`OFS_CTRL_SECOND, 8'hff);
		rd_chk(`OFS_CTRL_SECOND, 8'he7);
		wr(`OFS_CTRL_THIRD, 8'hff);
		rd_chk(`OFS_CTRL_THIRD, 8'hcf);
		check({30'h0, opamp_enable_o, bandgap_buffer_enable_o}, 32'h3);
		wr(`OFS_CTRL_THIRD, 8'h80);
		check({30'h0, opamp_enable_o, bandgap_buffer_enable_o}, 32'h2);
		wr(`OFS_CTRL_FIRST, 8'h7f);
		rd_chk(`OFS_CTRL_FIRST, 8'h20);
		check({31'h0, conv_power_o}, 32'h1);
		wr(4'h2, 8'hff);
		rd_chk(4'h2, 8'h00);
		wr(`OFS_CTRL_FIRST, 8'h00);
		check({31'h0, conv_power_o}, 32'h0);
	endtask

	// every input and reference code, forbidden one left out
	task automatic t_route();
		input_source_t s;
		reference_source_t r;
		logic [2:0] g;
		for (int c = 0; c < 8; c++) begin
			wr(`OFS_CTRL_SECOND, {c[2:0], 5'h00});
			s = (c == 1) ? SRC_SUPPLY : (c == 2) ? SRC_SUPPLY_HALF : (c == 3) ? SRC_SUPPLY_QUARTER :
				(c == 5) ? SRC_OPAMP : (c == 6) ? SRC_OPAMP_HALF : (c == 7) ? SRC_OPAMP_QUARTER : SRC_PIN;
			check({29'h0, route_o.source}, {29'h0, s});
		end
		// reference pin share bits set to one, zero
		wr(`OFS_PIN_SHARE, 8'h08);
		for (int c = 0; c < 16; c++) begin
			if (c == 9) continue;
			// opamp enabled while references are routed
			wr(`OFS_CTRL_THIRD, {4'h8, c[3:0]});
			r = (c >= 1 && c <= 4) ? REF_EXT : (c >= 10 && c <= 12) ? REF_BANDGAP : REF_SUPPLY;
			g = (c >= 1 && c <= 4) ? 3'(c) : (c >= 10 && c <= 12) ? 3'(c - 8) : 3'h1;
			check({29'h0, route_o.reference}, {29'h0, r});
			check({29'h0, route_o.ref_gain}, {29'h0, g});
			check({31'h0, route_o.opamp_from_bandgap}, {31'h0, c[3]});
		end
	endtask

	// tick spacing for all eight divide codes
	task automatic t_divider();
		int n;
		wr(`OFS_CTRL_FIRST, 8'h20);
		for (int c = 0; c < 8; c++) begin
			wr(`OFS_CTRL_SECOND, {5'h00, c[2:0]});
			repeat (2) gap(n);
			gap(n);
			check(32'(n), 32'(1) << c);
		end
	endtask

	// start pulse, busy polling, phase lengths, then an abort
	task automatic t_convert();
		logic [31:0] q;
		int k;
		// enable first, then let the converter settle
		wr(`OFS_CTRL_FIRST, 8'h20);
		repeat (50) @(posedge clk_i);
		// fsys/64 keeps the converter period at 640 ns
		wr(`OFS_CTRL_SECOND, 8'h06);
		wr(`OFS_CTRL_FIRST, 8'ha0);
		rd_chk(`OFS_CTRL_FIRST, 8'ha0);
		check({31'h0, conv_reset_o}, 32'h1);
		n_samp = 0;
		n_conv = 0;
		n_irq = 0;
		wr(`OFS_CTRL_FIRST, 8'h20);
		rd_chk(`OFS_CTRL_FIRST, 8'h60);
		k = 0;
		do begin
			wb(1'b0, `OFS_CTRL_FIRST, 8'h00, q);
			k++;
		end while (q[6] !== 1'b0 && k < 1000);
		if (q[6] !== 1'b0) begin
			mismatches++;
			close_out();
		end
		repeat (4) @(posedge clk_i);
		check(32'(n_samp), 32'd256);
		check(32'(n_conv), 32'd768);
		check(32'(n_irq), 32'd1);
		// a rise while sampling aborts the running conversion
		wr(`OFS_CTRL_FIRST, 8'ha0);
		wr(`OFS_CTRL_FIRST, 8'h20);
		rd_chk(`OFS_CTRL_FIRST, 8'h60);
		repeat (100) @(posedge clk_i);
		check({31'h0, sample_o}, 32'h1);
		wr(`OFS_CTRL_FIRST, 8'ha0);
		rd_chk(`OFS_CTRL_FIRST, 8'ha0);
		check({30'h0, sample_o, convert_o}, 32'h0);
		wr(`OFS_CTRL_FIRST, 8'h20);
		n_irq = 0;
		wr(`OFS_CTRL_FIRST, 8'h00);
		rd_chk(`OFS_CTRL_FIRST, 8'h00);
		repeat (1100) @(posedge clk_i);
		check({30'h0, sample_o, convert_o}, 32'h0);
		check(32'(n_irq), 32'd0);
	endtask

	// analog pins drop pull-up and drive, others follow the port
	task automatic t_pins();
		pull_up_req_i <= 8'hff;
		port_dir_out_i <= 8'ha5;
		wr(`OFS_PIN_SHARE, 8'h3c);
		check({24'h0, pin_analog_o}, 32'h3c);
		check({24'h0, pull_up_o}, 32'hc3);
		check({24'h0, digital_out_en_o}, 32'h81);
	endtask

	// main sequence
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		t_route();
		t_divider();
		t_convert();
		t_pins();
		close_out();
	end
endmodule
